// ==== logic/ext_bus_pkg.sv ====
// constants, types and register layout of the external bus interface
package ext_bus_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam int          REG_ADDR_W     = 2;
    localparam logic [1:0]  OFS_CTRL       = 2'h0;
    localparam logic [1:0]  OFS_STATUS     = 2'h1;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;

    // control fields
    localparam int          CTRL_SINGLE_BIT = 0;
    localparam int          CTRL_MUX_BIT    = 1;
    localparam int          CTRL_WIDE_LSB   = 2;
    localparam int          CTRL_WIDE_W     = 3;

    // status fields
    localparam int          STAT_MICRO_BIT  = 0;
    localparam int          STAT_BYTE8_BIT  = 1;
    localparam int          STAT_HOLD_BIT   = 2;
    localparam int          STAT_BUSY_BIT   = 3;
    localparam int          STAT_SINGLE_BIT = 4;
    localparam int          STAT_MUX_BIT    = 5;

    // ---------------------------------------------------------------
    // bus geometry and timing
    // ---------------------------------------------------------------
    localparam int          ADDR_W         = 24;
    localparam int          DATA_W         = 16;
    localparam int          SPACES         = 4;
    localparam logic [1:0]  SPACE_BYTE_PIN = 2'h3;
    localparam int          SPACE_MSB      = 23;
    localparam int          SPACE_LSB      = 22;
    localparam int          SYNC_STAGES    = 2;
    localparam int          CLK_PERIOD_NS  = 10;
    // strobe phase must outlast the data synchroniser
    localparam int          STROBE_MIN_NS  = 30;
    localparam logic [1:0]  STROBE_MIN_CYC =
        2'((STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ADDR   = 3'b001,
        ST_STROBE = 3'b011,
        ST_END    = 3'b010,
        ST_HOLD   = 3'b110
    } bus_state_t;

    typedef struct packed {
        logic                write;
        logic                word;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } bus_req_t;

    typedef struct packed {
        logic [CTRL_WIDE_W-1:0] wide;
        logic                   mux;
        logic                   single;
    } bus_ctrl_t;

endpackage : ext_bus_pkg

// ==== logic/pin_sync.sv ====
// multi-bit two-flop synchroniser for pin inputs
module pin_sync #(
    parameter int         WIDTH    = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             SYS_CLK,
    input  wire logic             RST,
    input  wire logic [WIDTH-1:0] PIN_IN,
    output logic      [WIDTH-1:0] SYNC_OUT
);

    // ---------------------------------------------------------------
    // stages
    // ---------------------------------------------------------------
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            meta_reg <= RESET_VAL;
            SYNC_OUT <= RESET_VAL;
        end else begin
            meta_reg <= PIN_IN;
            SYNC_OUT <= meta_reg;
        end
    end

endmodule : pin_sync

// ==== logic/external_bus_interface.sv ====
// external memory bus interface: cycle engine, pin drivers, registers
//
// How it works
// R01: reset pin low keeps engine reset
// R02: mode pin low means single chip
// R03: space three width follows width pin
// R04: separate bus: low byte D0-7, high if wide
// R05: address bit 23 driven inverted
// R06: multiplexed low lines: address, then data
// R07: wide multiplexed high lines: address, then data
// R08: four chip selects, one per space
// R09: dual strobes: even low, odd high
// R10: single strobe, upper enable on odd
// R11: read strobe low during reads
// R12: single strobe forced for narrow bus
// R13: latch strobe marks valid address
// R14: hold request low keeps hold state
// R15: grant acknowledge low throughout hold
// R16: wait request low extends strobe
// R17: address phase first, latch strobe only there
// R18: wait sampled each edge, pins steady
//
// Local design decisions: the strobed register port and the register addresses.
module external_bus_interface (
    input  wire logic                        SYS_CLK,
    input  wire logic                        RST,
    input  wire logic                        RESET_PIN_N,
    input  wire logic                        PROCESSOR_MODE_SELECT,
    input  wire logic                        BUS_WIDTH_SELECT,
    input  wire logic                        HOLD_REQ_N,
    input  wire logic                        WAIT_REQ_N,
    input  wire logic                        REQ_VALID,
    input  wire ext_bus_pkg::bus_req_t       REQ,
    output logic                             REQ_READY,
    output logic                             RSP_VALID,
    output logic                             RSP_ERROR,
    output logic [ext_bus_pkg::DATA_W-1:0]   RSP_RDATA,
    input  wire logic [ext_bus_pkg::REG_ADDR_W-1:0] REG_ADDR,
    input  wire logic [7:0]                  REG_WDATA,
    input  wire logic                        REG_WR,
    input  wire logic                        REG_RD,
    output logic [7:0]                       REG_RDATA,
    output logic [ext_bus_pkg::ADDR_W-1:0]   ADDR_OUT,
    output logic [ext_bus_pkg::DATA_W-1:0]   DATA_OUT,
    output logic [ext_bus_pkg::DATA_W-1:0]   DATA_OE,
    input  wire logic [ext_bus_pkg::DATA_W-1:0] DATA_IN,
    output logic [ext_bus_pkg::SPACES-1:0]   CHIP_SELECT_N,
    output logic                             ADDRESS_LATCH_STROBE,
    output logic                             READ_STROBE_N,
    output logic                             LOW_BYTE_WRITE_STROBE_N,
    output logic                             HIGH_BYTE_WRITE_STROBE_N,
    output logic                             UPPER_BYTE_ENABLE_N,
    output logic                             BUS_GRANT_ACK_N,
    output logic                             BUS_DRIVE_EN
);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [4:0]                      ctl_sync;
    logic [ext_bus_pkg::DATA_W-1:0]  din_sync;
    logic                            pin_rst_n;
    logic                            mode_pin;
    logic                            width_pin;
    logic                            hold_n;
    logic                            wait_n;

    pin_sync #(.WIDTH(5), .RESET_VAL(5'h07)) u_ctl_sync (
        .SYS_CLK  (SYS_CLK),
        .RST      (RST),
        .PIN_IN   ({RESET_PIN_N, PROCESSOR_MODE_SELECT, BUS_WIDTH_SELECT,
                    HOLD_REQ_N, WAIT_REQ_N}),
        .SYNC_OUT (ctl_sync)
    );

    pin_sync #(.WIDTH(ext_bus_pkg::DATA_W)) u_din_sync (
        .SYS_CLK  (SYS_CLK),
        .RST      (RST),
        .PIN_IN   (DATA_IN),
        .SYNC_OUT (din_sync)
    );

    assign pin_rst_n = ctl_sync[4];
    assign mode_pin  = ctl_sync[3];
    assign width_pin = ctl_sync[2];
    assign hold_n    = ctl_sync[1];
    assign wait_n    = ctl_sync[0];

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    ext_bus_pkg::bus_state_t   state_reg, state_next;
    ext_bus_pkg::bus_req_t     req_reg, req_next;
    ext_bus_pkg::bus_ctrl_t    ctrl_reg, ctrl_next;
    logic                      straps_ok_reg;
    logic                      micro_reg, micro_next;
    logic                      byte8_reg, byte8_next;
    logic                      beat_reg, beat_next;
    logic [1:0]                cnt_reg, cnt_next;
    logic [ext_bus_pkg::DATA_W-1:0] rdata_reg, rdata_next;

    // ---------------------------------------------------------------
    // request decode
    // ---------------------------------------------------------------
    wire        accept     = REQ_VALID & REQ_READY;
    wire        in_pin_rst = ~pin_rst_n;
    wire  [1:0] space      =
        req_next.addr[ext_bus_pkg::SPACE_MSB:ext_bus_pkg::SPACE_LSB];
    wire        wide       = (space == ext_bus_pkg::SPACE_BYTE_PIN) ?
                             ~byte8_reg : // [R03]
                             ctrl_reg.wide[space];
    wire        single_eff = ctrl_reg.single | ~wide; // [R12]
    wire [23:0] base_addr  = req_next.word ?
                             {req_next.addr[23:1], 1'b0} : req_next.addr;
    wire [23:0] beat_addr  = {base_addr[23:1], base_addr[0] | beat_next};
    wire        lane_lo    = wide ? (req_next.word | ~beat_addr[0]) : 1'b1;
    wire        lane_hi    = wide ? (req_next.word | beat_addr[0]) : 1'b0;
    wire        odd_access = wide ? lane_hi : beat_addr[0];
    wire        last_beat  = wide | ~req_next.word | beat_reg;
    wire [15:0] wdata_wide = req_next.word ? req_next.wdata :
                             beat_addr[0] ? {req_next.wdata[7:0], 8'h00} :
                                            {8'h00, req_next.wdata[7:0]};
    wire [15:0] wdata_lane = wide ? wdata_wide :
                             {8'h00, beat_next ? req_next.wdata[15:8] :
                                                 req_next.wdata[7:0]};
    wire [15:0] lane_oe    = {{8{lane_hi}}, {8{lane_lo}}}; // [R04]
    wire        wait_done  = (cnt_reg >= ext_bus_pkg::STROBE_MIN_CYC - 2'h1)
                             & wait_n; // [R16] [R18]
    wire        strobe_end = (state_reg == ext_bus_pkg::ST_STROBE)
                             & wait_done;

    // ---------------------------------------------------------------
    // cycle sequencer
    // ---------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        req_next   = accept ? REQ : req_reg;
        beat_next  = beat_reg;
        cnt_next   = 2'h0;
        unique case (state_reg)
            ext_bus_pkg::ST_IDLE: begin
                beat_next = 1'b0;
                if (accept && micro_reg) begin
                    state_next = ext_bus_pkg::ST_ADDR; // [R17]
                end else if (!accept && !hold_n) begin
                    state_next = ext_bus_pkg::ST_HOLD; // [R14]
                end
            end
            ext_bus_pkg::ST_ADDR: begin
                state_next = ext_bus_pkg::ST_STROBE; // [R17]
            end
            ext_bus_pkg::ST_STROBE: begin
                if (wait_done) begin
                    state_next = ext_bus_pkg::ST_END;
                end else begin
                    cnt_next = cnt_reg + 2'h1; // [R18]
                end
            end
            ext_bus_pkg::ST_END: begin
                if (last_beat) begin
                    state_next = ext_bus_pkg::ST_IDLE;
                end else begin
                    state_next = ext_bus_pkg::ST_ADDR;
                    beat_next  = 1'b1;
                end
            end
            ext_bus_pkg::ST_HOLD: begin
                if (hold_n) begin
                    state_next = ext_bus_pkg::ST_IDLE; // [R14]
                end
            end
            default: begin
                state_next = ext_bus_pkg::ST_IDLE;
            end
        endcase
        if (in_pin_rst) begin
            state_next = ext_bus_pkg::ST_IDLE; // [R01]
            beat_next  = 1'b0;
        end
    end

    // read lanes are picked from the synchronised bus, which lags the
    // pins by two edges; the minimum strobe length covers that lag
    always_comb begin
        rdata_next = rdata_reg;
        if (strobe_end && !req_reg.write) begin
            if (wide && req_reg.word) begin
                rdata_next = din_sync;
            end else if (wide) begin
                rdata_next = {8'h00, beat_addr[0] ? din_sync[15:8] :
                                                    din_sync[7:0]};
            end else if (beat_reg) begin
                rdata_next = {din_sync[7:0], rdata_reg[7:0]};
            end else begin
                rdata_next = {8'h00, din_sync[7:0]};
            end
        end
    end

    // ---------------------------------------------------------------
    // pin values one edge ahead, so every pin leaves a flop
    // ---------------------------------------------------------------
    wire        nx_addr_ph = (state_next == ext_bus_pkg::ST_ADDR);
    wire        nx_strobe  = (state_next == ext_bus_pkg::ST_STROBE);
    wire        nx_active  = nx_addr_ph | nx_strobe;
    wire        nx_hold    = (state_next == ext_bus_pkg::ST_HOLD);
    wire        nx_wr      = nx_strobe & req_next.write;
    wire [15:0] mux_addr   = {wide ? beat_addr[15:8] : 8'h00,
                              beat_addr[7:0]}; // [R06] [R07]
    wire [15:0] mux_oe     = {{8{wide}}, 8'hFF};
    wire [15:0] dout_next  = (nx_addr_ph && ctrl_reg.mux) ? mux_addr :
                             wdata_lane;
    wire [15:0] doe_next   = (nx_addr_ph && ctrl_reg.mux) ? mux_oe :
                             nx_wr ? lane_oe : 16'h0000; // [R04]
    wire [23:0] aout_next  = {~beat_addr[23], beat_addr[22:0]}; // [R05]
    wire [3:0]  cs_next    = nx_active ?
                             ~(4'h1 << space) : 4'hF; // [R08]
    wire        wrl_next   = ~(nx_wr & (single_eff | lane_lo)); // [R09] [R10]
    wire        wrh_next   = ~(nx_wr & ~single_eff & lane_hi); // [R09]
    wire        bhe_next   = ~(nx_active & single_eff & odd_access); // [R10]
    wire        rd_next    = ~(nx_strobe & ~req_next.write); // [R11]
    wire        ale_next   = nx_addr_ph; // [R13] [R17]
    wire        ready_next = (state_next == ext_bus_pkg::ST_IDLE)
                             & ~in_pin_rst & ~(accept & micro_reg);
    wire        rsp_next   = (strobe_end & last_beat) |
                             (accept & ~micro_reg); // [R02]

    // ---------------------------------------------------------------
    // straps and register port
    // ---------------------------------------------------------------
    // straps are taken after release and again while the pin reset holds
    assign micro_next = (!straps_ok_reg || in_pin_rst) ? mode_pin :
                        micro_reg; // [R02]
    assign byte8_next = (!straps_ok_reg || in_pin_rst) ? width_pin :
                        byte8_reg; // [R03]

    wire        wr_ctrl   = REG_WR & (REG_ADDR == ext_bus_pkg::OFS_CTRL);
    assign ctrl_next = in_pin_rst ? ext_bus_pkg::bus_ctrl_t'(
                           ext_bus_pkg::CTRL_RESET[4:0]) :
                       wr_ctrl ? ext_bus_pkg::bus_ctrl_t'(REG_WDATA[4:0]) :
                       ctrl_reg; // [R01]

    wire [7:0]  status_val = {2'b00, ctrl_reg.mux, single_eff,
                              state_reg != ext_bus_pkg::ST_IDLE,
                              state_reg == ext_bus_pkg::ST_HOLD,
                              byte8_reg, micro_reg};
    wire [7:0]  rdata_sel  =
        (REG_ADDR == ext_bus_pkg::OFS_CTRL)   ? {3'b000, ctrl_reg} :
        (REG_ADDR == ext_bus_pkg::OFS_STATUS) ? status_val : 8'h00;

    // ---------------------------------------------------------------
    // flops
    // ---------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_reg     <= ext_bus_pkg::ST_IDLE;
            req_reg       <= '0;
            ctrl_reg      <= ext_bus_pkg::bus_ctrl_t'(
                                 ext_bus_pkg::CTRL_RESET[4:0]);
            straps_ok_reg <= 1'b0;
            micro_reg     <= 1'b0;
            byte8_reg     <= 1'b0;
            beat_reg      <= 1'b0;
            cnt_reg       <= 2'h0;
            rdata_reg     <= 16'h0000;
        end else begin
            state_reg     <= state_next;
            req_reg       <= req_next;
            ctrl_reg      <= ctrl_next;
            straps_ok_reg <= pin_rst_n;
            micro_reg     <= micro_next;
            byte8_reg     <= byte8_next;
            beat_reg      <= beat_next;
            cnt_reg       <= cnt_next;
            rdata_reg     <= rdata_next;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            REQ_READY                <= 1'b0;
            RSP_VALID                <= 1'b0;
            RSP_ERROR                <= 1'b0;
            RSP_RDATA                <= 16'h0000;
            REG_RDATA                <= 8'h00;
            ADDR_OUT                 <= 24'h800000;
            DATA_OUT                 <= 16'h0000;
            DATA_OE                  <= 16'h0000;
            CHIP_SELECT_N            <= 4'hF;
            ADDRESS_LATCH_STROBE     <= 1'b0;
            READ_STROBE_N            <= 1'b1;
            LOW_BYTE_WRITE_STROBE_N  <= 1'b1;
            HIGH_BYTE_WRITE_STROBE_N <= 1'b1;
            UPPER_BYTE_ENABLE_N      <= 1'b1;
            BUS_GRANT_ACK_N          <= 1'b1;
            BUS_DRIVE_EN             <= 1'b0;
        end else begin
            REQ_READY                <= ready_next;
            RSP_VALID                <= rsp_next;
            RSP_ERROR                <= accept & ~micro_reg;
            RSP_RDATA                <= rdata_next;
            REG_RDATA                <= REG_RD ? rdata_sel : 8'h00;
            ADDR_OUT                 <= aout_next;
            DATA_OUT                 <= dout_next; // [R18]
            DATA_OE                  <= doe_next;
            CHIP_SELECT_N            <= cs_next;
            ADDRESS_LATCH_STROBE     <= ale_next;
            READ_STROBE_N            <= rd_next;
            LOW_BYTE_WRITE_STROBE_N  <= wrl_next;
            HIGH_BYTE_WRITE_STROBE_N <= wrh_next;
            UPPER_BYTE_ENABLE_N      <= bhe_next;
            BUS_GRANT_ACK_N          <= ~nx_hold; // [R15]
            // drivers float while another master owns the bus
            BUS_DRIVE_EN             <= micro_next & ~nx_hold;
        end
    end

endmodule : external_bus_interface

// ==== sim/external_bus_interface_sva.sv ====
// pin-level assertion checker for the external bus interface
module external_bus_interface_sva (
    input wire logic        SYS_CLK,
    input wire logic        RST,
    input wire logic        HOLD_REQ_N,
    input wire logic        WAIT_REQ_N,
    input wire logic [23:0] ADDR_OUT,
    input wire logic [15:0] DATA_OE,
    input wire logic [3:0]  CHIP_SELECT_N,
    input wire logic        ADDRESS_LATCH_STROBE,
    input wire logic        READ_STROBE_N,
    input wire logic        LOW_BYTE_WRITE_STROBE_N,
    input wire logic        HIGH_BYTE_WRITE_STROBE_N,
    input wire logic        UPPER_BYTE_ENABLE_N,
    input wire logic        BUS_GRANT_ACK_N,
    input wire logic        BUS_DRIVE_EN
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // pin relations
    // ---------------------------------------------------------------
    wire quiet = READ_STROBE_N && LOW_BYTE_WRITE_STROBE_N
        && HIGH_BYTE_WRITE_STROBE_N;
    wire no_cs = CHIP_SELECT_N == 4'hF;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    chk_cs_single: assert property ($onehot0(~CHIP_SELECT_N))
        else $error("several chip selects active");
    chk_cs_decode: assert property (!no_cs |->
        !CHIP_SELECT_N[{~ADDR_OUT[23], ADDR_OUT[22]}])
        else $error("chip select off address");
    chk_read_alone: assert property (!READ_STROBE_N |->
        LOW_BYTE_WRITE_STROBE_N && HIGH_BYTE_WRITE_STROBE_N && !no_cs)
        else $error("read strobe misused");
    chk_latch_first: assert property (ADDRESS_LATCH_STROBE |->
        quiet ##1 !ADDRESS_LATCH_STROBE && !quiet)
        else $error("latch strobe out of place");
    chk_strobe_min: assert property ($fell(READ_STROBE_N) |->
        !READ_STROBE_N[*3])
        else $error("read strobe too short");
    chk_pins_steady: assert property (!READ_STROBE_N
        && $past(READ_STROBE_N) == 1'b0 |->
        $stable(ADDR_OUT) && $stable(CHIP_SELECT_N) && $stable(DATA_OE))
        else $error("pins moved inside read strobe");
    chk_wait_extends: assert property (!READ_STROBE_N && !WAIT_REQ_N
        && $past(WAIT_REQ_N) == 1'b0 && $past(WAIT_REQ_N, 2) == 1'b0
        |=> !READ_STROBE_N)
        else $error("strobe released during wait");
    chk_upper_single: assert property (!UPPER_BYTE_ENABLE_N |->
        HIGH_BYTE_WRITE_STROBE_N)
        else $error("upper enable with high strobe");
    chk_hold_quiet: assert property (!BUS_GRANT_ACK_N |->
        quiet && no_cs && !ADDRESS_LATCH_STROBE && !BUS_DRIVE_EN
        && DATA_OE == 16'h0000)
        else $error("bus driven while granted away");
    chk_grant_cause: assert property ($fell(BUS_GRANT_ACK_N) |->
        $past(HOLD_REQ_N, 3) == 1'b0)
        else $error("grant without hold request");
    chk_hold_stays: assert property (!BUS_GRANT_ACK_N && !HOLD_REQ_N
        && $past(HOLD_REQ_N) == 1'b0 && $past(HOLD_REQ_N, 2) == 1'b0
        |=> !BUS_GRANT_ACK_N)
        else $error("hold left while request low");
endmodule : external_bus_interface_sva

// ==== sim/ext_bus_mem_model.sv ====
// external memory model standing on the far side of the bus
module ext_bus_mem_model (
    input  wire logic        clk,
    input  wire logic [23:0] addr,
    input  wire logic [15:0] dout,
    input  wire logic [3:0]  cs_n,
    input  wire logic        ale,
    input  wire logic        rd_n,
    input  wire logic        wrl_n,
    input  wire logic        wrh_n,
    input  wire logic        ube_n,
    input  wire logic        muxed,
    input  wire logic        single,
    input  wire logic        slow,
    input  wire logic [3:0]  narrow,
    output logic      [15:0] din,
    output logic             wait_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // storage and pins
    // ---------------------------------------------------------------
    logic [7:0]  a, mem [0:255];
    logic [15:0] last = 16'h0F0F;
    logic [2:0]  cnt = 3'h0;
    wire strobe = !rd_n || !wrl_n || !wrh_n;
    wire nar = |(narrow & ~cs_n);
    wire [7:0] ae = {a[7:1], 1'b0};
    wire [7:0] ao = {a[7:1], 1'b1};
    // released lines flip each cycle, never hold old data
    assign din = (!rd_n && !(&cs_n)) ?
        (nar ? {~last[15:8], mem[a]} : {mem[ao], mem[ae]}) : ~last;
    // slow mode holds wait low for four strobe cycles
    assign wait_n = !(slow && strobe && cnt < 3'h4);

    always @(posedge clk) begin
        last <= din;
        if (ale) a <= muxed ? dout[7:0] : addr[7:0];
        if (!strobe) cnt <= 3'h0;
        else if (cnt != 3'h7) cnt <= cnt + 3'h1;
        if (nar && !wrl_n) mem[a] <= dout[7:0];
        if (!nar && !wrl_n && !(single && a[0])) mem[ae] <= dout[7:0];
        if (!nar && (single ? !wrl_n && !ube_n : !wrh_n))
            mem[ao] <= dout[15:8];
    end
endmodule : ext_bus_mem_model

// ==== sim/external_bus_interface_tb.sv ====
// self-checking bench for the external bus interface
module external_bus_interface_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic SYS_CLK, RST, RESET_PIN_N, PROCESSOR_MODE_SELECT, BUS_WIDTH_SELECT;
    logic HOLD_REQ_N, WAIT_REQ_N, REQ_VALID, REQ_READY, RSP_VALID, RSP_ERROR;
    logic REG_WR, REG_RD, ADDRESS_LATCH_STROBE, READ_STROBE_N, BUS_DRIVE_EN;
    logic LOW_BYTE_WRITE_STROBE_N, HIGH_BYTE_WRITE_STROBE_N;
    logic UPPER_BYTE_ENABLE_N, BUS_GRANT_ACK_N, e, slow;
    logic [15:0] RSP_RDATA, DATA_OUT, DATA_OE, DATA_IN, q;
    logic [23:0] ADDR_OUT;
    logic [3:0]  CHIP_SELECT_N;
    logic [1:0]  REG_ADDR;
    logic [7:0]  REG_WDATA, REG_RDATA, ctrl;
    ext_bus_pkg::bus_req_t REQ;
    int errors, checked, n, base;

    external_bus_interface dut_u (.*);
    ext_bus_mem_model mem_u (.clk(SYS_CLK), .addr(ADDR_OUT), .dout(DATA_OUT),
        .cs_n(CHIP_SELECT_N), .ale(ADDRESS_LATCH_STROBE),
        .rd_n(READ_STROBE_N), .wrl_n(LOW_BYTE_WRITE_STROBE_N),
        .wrh_n(HIGH_BYTE_WRITE_STROBE_N), .ube_n(UPPER_BYTE_ENABLE_N),
        .muxed(ctrl[1]), .single(ctrl[0]), .slow(slow),
        .narrow({BUS_WIDTH_SELECT, ~ctrl[4], ~ctrl[3], ~ctrl[2]}),
        .din(DATA_IN), .wait_n(WAIT_REQ_N));

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [15:0] s, input logic [15:0] x);
        checked++;
        if (s !== x) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, x);
        end
    endtask : check
    task automatic stop_test();
        if (errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge SYS_CLK);
        REG_WR <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [1:0] a, input logic [7:0] x,
                          input logic [7:0] m);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge SYS_CLK);
        REG_RD <= 1'b0;
        @(posedge SYS_CLK);
        check(16'(REG_RDATA & m), 16'(x));
    endtask : reg_rd
    task automatic cfg(input logic [7:0] v);
        ctrl = v;
        reg_wr(ext_bus_pkg::OFS_CTRL, v);
        reg_rd(ext_bus_pkg::OFS_CTRL, v, 8'h1F);
    endtask : cfg
    // pin reset recaptures the straps; REQ_READY is checked low meanwhile
    task automatic prst(input logic m, input logic b);
        RESET_PIN_N <= 1'b0;
        PROCESSOR_MODE_SELECT <= m;
        BUS_WIDTH_SELECT <= b;
        repeat (6) @(posedge SYS_CLK);
        check(16'(REQ_READY), 16'h0000);
        RESET_PIN_N <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
    endtask : prst
    task automatic xfer(input logic w, input logic wd,
                        input logic [23:0] a, input logic [15:0] d);
        int k = 0;
        REQ_VALID <= 1'b1;
        REQ <= '{w, wd, a, d};
        do begin @(posedge SYS_CLK); k++; end
        while (REQ_READY !== 1'b1 && k < 50);
        REQ_VALID <= 1'b0;
        n = 0;
        do begin @(posedge SYS_CLK); n++; end
        while (RSP_VALID !== 1'b1 && n < 60);
        q = RSP_RDATA;
        e = RSP_ERROR;
        if (k >= 50 || n >= 60) errors++;
    endtask : xfer

    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        #200000;
        errors++;
        stop_test();
    end
    initial begin
        errors = 0; checked = 0; ctrl = 8'h00; slow = 1'b0;
        RST = 1'b1; RESET_PIN_N = 1'b1; PROCESSOR_MODE_SELECT = 1'b0;
        BUS_WIDTH_SELECT = 1'b0; HOLD_REQ_N = 1'b1; REQ_VALID = 1'b0;
        REQ = '0; REG_ADDR = 2'h0; REG_WDATA = 8'h00;
        REG_WR = 1'b0; REG_RD = 1'b0;
        repeat (8) @(posedge SYS_CLK);
        RST <= 1'b0;
        repeat (4) @(posedge SYS_CLK);
        reg_rd(ext_bus_pkg::OFS_STATUS, 8'h00, 8'h01);
        xfer(1'b0, 1'b1, 24'h000010, 16'h0000);
        check(16'(e), 16'h0001);
        prst(1'b1, 1'b1);
        reg_rd(ext_bus_pkg::OFS_CTRL, ext_bus_pkg::CTRL_RESET, 8'hFF);
        reg_rd(2'h2, 8'h00, 8'hFF);
        reg_wr(ext_bus_pkg::OFS_STATUS, 8'hFF);
        reg_rd(ext_bus_pkg::OFS_STATUS, 8'h03, 8'h03);
        cfg(8'h1C);
        xfer(1'b1, 1'b1, 24'h000010, 16'hBEEF);
        cfg(8'h1E);
        xfer(1'b0, 1'b1, 24'h000010, 16'h0000);
        check(q, 16'hBEEF);
        base = n;
        xfer(1'b1, 1'b1, 24'h400020, 16'h1234);
        cfg(8'h1D);
        xfer(1'b1, 1'b1, 24'h800030, 16'h0F5A);
        cfg(8'h1C);
        xfer(1'b0, 1'b1, 24'h400020, 16'h0000);
        check(q, 16'h1234);
        xfer(1'b0, 1'b1, 24'h800030, 16'h0000);
        check(q, 16'h0F5A);
        xfer(1'b1, 1'b1, 24'hC00040, 16'hA55A);
        xfer(1'b0, 1'b1, 24'hC00040, 16'h0000);
        check(q, 16'hA55A);
        slow = 1'b1;
        xfer(1'b0, 1'b1, 24'h000010, 16'h0000);
        check(q, 16'hBEEF);
        check(16'(n > base + 1), 16'h0001);
        slow = 1'b0;
        HOLD_REQ_N <= 1'b0;
        repeat (6) @(posedge SYS_CLK);
        check(16'(BUS_GRANT_ACK_N), 16'h0000);
        check(16'(REQ_READY), 16'h0000);
        reg_rd(ext_bus_pkg::OFS_STATUS, 8'h04, 8'h04);
        repeat (10) @(posedge SYS_CLK);
        check(16'(BUS_GRANT_ACK_N), 16'h0000);
        HOLD_REQ_N <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
        check(16'(BUS_GRANT_ACK_N), 16'h0001);
        stop_test();
    end
endmodule : external_bus_interface_tb

bind external_bus_interface external_bus_interface_sva chk_u (.*);
